// [src/dpoam_pkg.sv]
/*
 Constants, register map and carrier types for the drop path overhead alarm monitor.
 Assumes one byte clock for the drop bus, the POH strobes and the Wishbone slave.
*/
package dpoam_pkg;
   // -------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // -------------------------------------------------------------
   localparam logic [7:0] DPOAM_IDX_STATUS = 8'h22; // Live alarm bits
   localparam logic [7:0] DPOAM_IDX_CTRL = 8'h30; // Control bits
   localparam logic [7:0] DPOAM_IDX_EVENT = 8'h31; // Sticky alarm rises, write one to clear
   localparam logic [7:0] DPOAM_IDX_MASK = 8'h32; // Interrupt mask
   localparam logic [7:0] DPOAM_IDX_C2EXP = 8'h75; // Expected signal label
   localparam logic [7:0] DPOAM_IDX_TRACE = 8'hf0; // Expected trace bytes F0..FF
   // -------------------------------------------------------------
   // Field positions and fixed values
   // -------------------------------------------------------------
   localparam int DPOAM_CTRL_PDO = 0; // Parity over data only
   localparam int DPOAM_CTRL_RDISEL = 1; // RDI count select
   localparam int DPOAM_CTRL_FVD = 2; // Fixed label compare disable
   localparam int DPOAM_CTRL_TCMP = 3; // Trace compare enable
   localparam int DPOAM_CTRL_TFMT = 4; // Trace format select
   localparam int DPOAM_CTRL_EXTERNAL_ALARM_PROCESSING_ENABLE = 5; // External alarm processing enable
   localparam int DPOAM_RDI_BIT = 3; // G1 bit 5 counted from the MSB
   localparam logic [7:0] DPOAM_FIXED_LABEL = 8'h01;
   localparam logic [3:0] DPOAM_LABEL_FRAMES = 4'h5;
   localparam logic [3:0] DPOAM_RDI_SHORT = 4'h5;
   localparam logic [3:0] DPOAM_RDI_LONG = 4'ha;
   localparam logic [1:0] DPOAM_LOCK_MSGS = 2'h2; // Aligned messages to declare lock
   localparam logic [7:0] DPOAM_CTRL_RESET = 8'h00;
   localparam logic [7:0] DPOAM_MASK_RESET = 8'h00;
   localparam logic [7:0] DPOAM_C2EXP_RESET = 8'h00;
   // -------------------------------------------------------------
   // Carriers
   // -------------------------------------------------------------
   typedef struct packed {
      logic [7:0] data; // Drop bus byte
      logic spe; // Payload indication
      logic c1j1; // Composite C1/J1 pulse
      logic c1; // C1 pulse used while tracking
      logic parity; // Odd parity input
   } dpoam_drop_t;
   typedef struct packed {
      logic g1; // Value holds the G1 byte
      logic c2; // Value holds the C2 byte
      logic j1; // Value holds one trace byte
      logic [7:0] value;
   } dpoam_poh_t;
   typedef struct packed {
      logic trace_pulse_loss; // Drop J1 pulse loss alarm
      logic orderwire_ais; // E1 AIS alarm
      logic path_ais; // External path AIS indication
      logic network_alarm; // External network alarm
      logic pointer_loss; // Receive pointer loss
      logic recv_path_ais; // Receive path AIS
   } dpoam_upstream_t;
endpackage

// [src/dpoam_monitor.sv]
/*
 Drop path overhead alarm monitor: parity, FIFO slip, RDI, label, trace alarms,
 Wishbone register slave and interrupt. Assumes POH strobes come at most once per
 frame per byte type and all inputs are synchronous to clock.
*/
`timescale 1ns/1ps
module dpoam_monitor import dpoam_pkg::*; (
   input wire logic clock,
   input wire logic rst,
   input wire dpoam_drop_t drop,
   input wire dpoam_poh_t poh,
   input wire dpoam_upstream_t upstream,
   input wire logic pointer_track_enable,
   input wire logic slip_overflow,
   input wire logic slip_underflow,
   output logic fifo_recenter,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq
);
   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   // Next run count of a persistence filter; restarts when input agrees with state
   function automatic logic [3:0] f_run(logic [3:0] cnt, logic cond, logic state, logic [3:0] lim);
      if (cond == state || cnt + 4'h1 >= lim) begin
         return 4'h0;
      end
      return cnt + 4'h1;
   endfunction
   // Registers
   logic [7:0] ctrl; // Control bits
   logic [7:0] event_flags; // Sticky rises
   logic [7:0] mask; // Interrupt mask
   logic [7:0] c2_expected; // Expected label
   logic [7:0] trace_exp [16]; // Expected trace message
   logic [7:0] trace_prev [16]; // Last received message
   logic [7:0] status; // Live alarms as read
   logic [7:0] status_q; // Previous status for rise detection
   // Alarm state
   logic rdi_state, slm_state, uneq_state, locked, tim_state, relock_wait;
   logic [3:0] rdi_cnt, slm_cnt, uneq_cnt;
   logic [3:0] pos; // Trace byte position
   logic [1:0] align_cnt;
   logic same_acc, match_acc;
   logic [3:0] exit_src_q; // Previous upstream alarm terms
   // -------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------
   wire [7:0] idx = wb_adr_i[9:2];
   wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wr_lo = bus_req && wb_we_i && wb_sel_i[0];
   wire wr_ctrl = wr_lo && idx == DPOAM_IDX_CTRL;
   wire wr_event = wr_lo && idx == DPOAM_IDX_EVENT;
   wire wr_mask = wr_lo && idx == DPOAM_IDX_MASK;
   wire wr_c2 = wr_lo && idx == DPOAM_IDX_C2EXP;
   wire wr_trace = wr_lo && idx[7:4] == DPOAM_IDX_TRACE[7:4];
   wire [7:0] rd_byte = idx == DPOAM_IDX_STATUS ? status :
      idx == DPOAM_IDX_CTRL ? ctrl :
      idx == DPOAM_IDX_EVENT ? event_flags :
      idx == DPOAM_IDX_MASK ? mask :
      idx == DPOAM_IDX_C2EXP ? c2_expected :
      idx[7:4] == DPOAM_IDX_TRACE[7:4] ? trace_exp[idx[3:0]] : 8'h00;
   // -------------------------------------------------------------
   // Parity and slip
   // -------------------------------------------------------------
   // Odd parity: a good byte group plus its parity bit holds an odd count of ones
   wire par_full = ^{drop.data, drop.spe, drop.c1j1, drop.parity};
   wire par_track = ^{drop.data, drop.c1, drop.parity};
   wire par_data = ^{drop.data, drop.parity};
   wire parity_err = ctrl[DPOAM_CTRL_PDO] ? !par_data :
      pointer_track_enable ? !par_track : !par_full;
   wire slip = slip_overflow || slip_underflow;
   // -------------------------------------------------------------
   // Label and RDI filters
   // -------------------------------------------------------------
   wire [3:0] rdi_lim = ctrl[DPOAM_CTRL_RDISEL] ? DPOAM_RDI_LONG : DPOAM_RDI_SHORT;
   wire rdi_in = poh.value[DPOAM_RDI_BIT];
   wire rdi_flip = poh.g1 && rdi_in != rdi_state && rdi_cnt + 4'h1 >= rdi_lim;
   // Unmatched against programmed label and, unless disabled, the fixed label
   wire slm_in = poh.value != c2_expected &&
      (ctrl[DPOAM_CTRL_FVD] || poh.value != DPOAM_FIXED_LABEL);
   wire slm_flip = poh.c2 && slm_in != slm_state && slm_cnt + 4'h1 >= DPOAM_LABEL_FRAMES;
   wire uneq_in = poh.value == 8'h00;
   wire uneq_flip = poh.c2 && uneq_in != uneq_state && uneq_cnt + 4'h1 >= DPOAM_LABEL_FRAMES;
   // -------------------------------------------------------------
   // Trace alignment
   // -------------------------------------------------------------
   wire trace_en = ctrl[DPOAM_CTRL_TCMP] && ctrl[DPOAM_CTRL_TFMT];
   wire external_alarm_processing_enable = ctrl[DPOAM_CTRL_EXTERNAL_ALARM_PROCESSING_ENABLE];
   // Upstream alarm terms whose exit forces a relock
   wire [3:0] exit_src = {upstream.trace_pulse_loss, upstream.orderwire_ais,
      upstream.path_ais || upstream.network_alarm, upstream.pointer_loss || upstream.recv_path_ais};
   wire [3:0] exit_sel = {!pointer_track_enable, !external_alarm_processing_enable, external_alarm_processing_enable, pointer_track_enable};
   wire alarm_exit = |(exit_src_q & ~exit_src & exit_sel);
   wire marker = poh.value[7];
   wire [3:0] byte_idx = marker ? 4'h0 : pos + 4'h1;
   wire aligned_byte = marker == (pos == 4'hf); // Marker exactly at message start
   wire same_now = (byte_idx == 4'h0 || same_acc) && poh.value == trace_prev[byte_idx];
   wire match_now = (byte_idx == 4'h0 || match_acc) && poh.value == trace_exp[byte_idx];
   wire msg_done = poh.j1 && byte_idx == 4'hf && locked;
   wire next_locked = !trace_en || alarm_exit ? 1'b0 :
      poh.j1 && !aligned_byte ? 1'b0 :
      poh.j1 && marker && align_cnt + 2'h1 >= DPOAM_LOCK_MSGS ? 1'b1 : locked;
   wire tim_set = msg_done && same_now && !match_now;
   wire tim_clr = msg_done && same_now && match_now && relock_wait;
   // Alarm bits as software sees them
   wire [7:0] next_status = {parity_err, slip, rdi_state, slm_state && !uneq_state,
      uneq_state, trace_en && !locked, tim_state, 1'b0};
   // -------------------------------------------------------------
   // Wishbone slave: ack one cycle after the request
   // -------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req && !wb_we_i ? {24'h0, rd_byte} : 32'h0;
      end
   end
   // Software-written control registers
   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl <= DPOAM_CTRL_RESET;
         mask <= DPOAM_MASK_RESET;
         c2_expected <= DPOAM_C2EXP_RESET;
      end else begin
         if (wr_ctrl) ctrl <= wb_dat_i[7:0];
         if (wr_mask) mask <= wb_dat_i[7:0];
         if (wr_c2) c2_expected <= wb_dat_i[7:0];
      end
   end
   // Expected trace is plain storage, no reset needed
   always_ff @(posedge clock) begin
      if (wr_trace) trace_exp[idx[3:0]] <= wb_dat_i[7:0];
      if (poh.j1) trace_prev[byte_idx] <= poh.value;
   end
   // -------------------------------------------------------------
   // Status, sticky events and interrupt
   // -------------------------------------------------------------
   // A rise in the same cycle as a write-one clear keeps the flag set
   always_ff @(posedge clock) begin
      if (rst) begin
         status <= 8'h00;
         status_q <= 8'h00;
         event_flags <= 8'h00;
         irq <= 1'b0;
      end else begin
         status <= next_status;
         status_q <= status;
         event_flags <= (event_flags & ~(wr_event ? wb_dat_i[7:0] : 8'h00)) | (status & ~status_q);
         irq <= |(event_flags & mask);
      end
   end
   // FIFO recenter follows every slip; the datapath does the rest
   always_ff @(posedge clock) begin
      if (rst) fifo_recenter <= 1'b0;
      else fifo_recenter <= slip;
   end
   // -------------------------------------------------------------
   // Frame-rate persistence filters
   // -------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         rdi_state <= 1'b0;
         rdi_cnt <= 4'h0;
         slm_state <= 1'b0;
         slm_cnt <= 4'h0;
         uneq_state <= 1'b0;
         uneq_cnt <= 4'h0;
      end else begin
         if (poh.g1) rdi_cnt <= f_run(rdi_cnt, rdi_in, rdi_state, rdi_lim);
         if (rdi_flip) rdi_state <= rdi_in;
         if (poh.c2) slm_cnt <= f_run(slm_cnt, slm_in, slm_state, DPOAM_LABEL_FRAMES);
         if (slm_flip) slm_state <= slm_in;
         if (poh.c2) uneq_cnt <= f_run(uneq_cnt, uneq_in, uneq_state, DPOAM_LABEL_FRAMES);
         if (uneq_flip) uneq_state <= uneq_in;
      end
   end
   // -------------------------------------------------------------
   // Trace machine
   // -------------------------------------------------------------
   // Lock drops at once on any misplaced marker; two aligned messages relock
   always_ff @(posedge clock) begin
      if (rst) begin
         pos <= 4'h0;
         align_cnt <= 2'h0;
         locked <= 1'b0;
         same_acc <= 1'b0;
         match_acc <= 1'b0;
         exit_src_q <= 4'h0;
      end else begin
         exit_src_q <= exit_src;
         locked <= next_locked;
         if (poh.j1) begin
            pos <= byte_idx;
            same_acc <= same_now;
            match_acc <= match_now;
         end
         if (!next_locked && (!aligned_byte && poh.j1 || !trace_en || alarm_exit)) align_cnt <= 2'h0;
         else if (poh.j1 && marker && align_cnt < DPOAM_LOCK_MSGS) align_cnt <= align_cnt + 2'h1;
      end
   end
   // Mismatch holds until a relock on a stable, matching message
   always_ff @(posedge clock) begin
      if (rst) begin
         tim_state <= 1'b0;
         relock_wait <= 1'b0;
      end else begin
         if (tim_set) tim_state <= 1'b1;
         else if (tim_clr) tim_state <= 1'b0;
         if (locked && !next_locked) relock_wait <= 1'b1;
         else if (tim_clr) relock_wait <= 1'b0;
      end
   end
   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   logic [3:0] rdi_run; // Consecutive G1 frames with RDI set
   logic [3:0] zero_run; // Consecutive zero C2 frames
   logic [3:0] miss_run; // Consecutive unmatched C2 frames
   // Run counters saturate so a long alarm cannot wrap back under the limit
   always_ff @(posedge clock) begin
      if (rst) begin
         rdi_run <= 4'h0;
         zero_run <= 4'h0;
         miss_run <= 4'h0;
      end else begin
         if (poh.g1) rdi_run <= rdi_in ? (rdi_run == 4'hf ? rdi_run : rdi_run + 4'h1) : 4'h0;
         if (poh.c2) zero_run <= uneq_in ? (zero_run == 4'hf ? zero_run : zero_run + 4'h1) : 4'h0;
         if (poh.c2) miss_run <= slm_in ? (miss_run == 4'hf ? miss_run : miss_run + 4'h1) : 4'h0;
      end
   end
   // Parity checks watch the status bit one edge after the byte
   a_parity_data_only: assert property (@(posedge clock) disable iff (rst)
      ctrl[DPOAM_CTRL_PDO] && (^{drop.data, drop.parity}) == 1'b0 |=> status[7])
      else $error("data-only parity error not flagged");
   a_parity_full: assert property (@(posedge clock) disable iff (rst)
      !ctrl[DPOAM_CTRL_PDO] && !pointer_track_enable && (^{drop.data, drop.spe, drop.c1j1, drop.parity}) |=> !status[7])
      else $error("good full parity flagged");
   a_parity_track: assert property (@(posedge clock) disable iff (rst)
      !ctrl[DPOAM_CTRL_PDO] && pointer_track_enable && !(^{drop.data, drop.c1, drop.parity}) |=> status[7])
      else $error("tracking parity error missed");
   a_slip_recenter: assert property (@(posedge clock) disable iff (rst)
      slip_overflow || slip_underflow |=> fifo_recenter && status[6])
      else $error("slip not reported or recentered");
   a_rdi_frames: assert property (@(posedge clock) disable iff (rst)
      $rose(rdi_state) |-> rdi_run >= $past(rdi_lim))
      else $error("RDI declared too early");
   a_label_suppress: assert property (@(posedge clock) disable iff (rst)
      status[3] |-> !status[4])
      else $error("label mismatch shown while unequipped");
   a_uneq_frames: assert property (@(posedge clock) disable iff (rst)
      $rose(uneq_state) |-> zero_run >= DPOAM_LABEL_FRAMES)
      else $error("unequipped declared too early");
   a_trace_disabled: assert property (@(posedge clock) disable iff (rst)
      !trace_en |=> !status[2])
      else $error("loss of lock shown while trace disabled");
   a_exit_lol: assert property (@(posedge clock) disable iff (rst)
      alarm_exit && trace_en && $stable(ctrl) |=> !locked ##1 status[2])
      else $error("alarm exit did not drop lock");
   a_tim_hold: assert property (@(posedge clock) disable iff (rst)
      tim_state && !relock_wait |=> tim_state)
      else $error("mismatch cleared without relock");
   a_ack_single: assert property (@(posedge clock) disable iff (rst)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
   // Label, trace and recenter checks; the label timing check leans on the run counters above
   a_label_frames: assert property (@(posedge clock) disable iff (rst)
      $rose(slm_state) |-> miss_run >= DPOAM_LABEL_FRAMES)
      else $error("label mismatch declared too early");
   a_label_shown: assert property (@(posedge clock) disable iff (rst)
      slm_state && !uneq_state |=> status[4])
      else $error("label mismatch not shown");
   a_tim_set: assert property (@(posedge clock) disable iff (rst)
      tim_set |=> tim_state)
      else $error("trace mismatch not raised");
   a_recenter_pulse: assert property (@(posedge clock) disable iff (rst)
      fifo_recenter |-> $past(slip_overflow) || $past(slip_underflow))
      else $error("recenter without a slip");
   // Bus and interrupt checks
   a_event_sticky: assert property (@(posedge clock) disable iff (rst)
      event_flags[7] && !(wr_event && wb_dat_i[7]) |=> event_flags[7])
      else $error("sticky flag lost without a clear");
   a_irq_follow: assert property (@(posedge clock) disable iff (rst)
      |(event_flags & mask) |=> irq)
      else $error("unmasked event without interrupt");
   a_dat_idle: assert property (@(posedge clock) disable iff (rst)
      !wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   c_rdi_raise: cover property (@(posedge clock) disable iff (rst) $rose(rdi_state));
   c_tim_raise: cover property (@(posedge clock) disable iff (rst) $rose(tim_state));
   c_tim_clear: cover property (@(posedge clock) disable iff (rst) $fell(tim_state));
   c_irq_raise: cover property (@(posedge clock) disable iff (rst) $rose(irq));
   c_label_suppressed: cover property (@(posedge clock) disable iff (rst) uneq_state && slm_state);
endmodule

// [testbench/dpoam_drop_source.sv]
/*
 Drop bus source standing in for the upstream framing logic.
 Assumes the monitor samples the drop bus on every rising edge of clock.
*/
`timescale 1ns/1ps
module dpoam_drop_source import dpoam_pkg::*; (
   input wire logic clock,
   input wire logic rst,
   input wire logic [1:0] cover_sel,
   output dpoam_drop_t drop
);
   // ----------------------------------------
   // Byte counter and parity coverage
   // ----------------------------------------
   logic [7:0] count; // Running data byte
   logic par_full; // Data, SPE and C1J1
   logic par_track; // Data and C1
   logic par_data; // Data only
   // New byte each cycle so every parity case sees varied data
   always_ff @(posedge clock) begin
      if (rst) begin
         count <= 8'h00;
      end else begin
         count <= count + 8'h01;
      end
   end
   // SPE high and C1 low: full parity differs from both tracking and data-only parity
   assign par_full = ~^{count, 1'b1, 1'b0};
   assign par_track = ~^{count, 1'b0};
   assign par_data = ~^count;
   assign drop = '{data: count, spe: 1'b1, c1j1: 1'b0, c1: 1'b0,
                   parity: (cover_sel == 2'h0) ? par_full : (cover_sel == 2'h1) ? par_track : par_data};
endmodule

// [testbench/drop_path_overhead_alarm_monitor_tb.sv]
/*
 Self-checking bench for the drop path overhead alarm monitor.
 Assumes a one-cycle Wishbone ack and live status one edge behind its cause.
*/
`timescale 1ns/1ps
module drop_path_overhead_alarm_monitor_tb import dpoam_pkg::*;;
   // ----------------------------------------
   // Stimulus signals
   // ----------------------------------------
   logic clock = 1'b0;
   logic rst = 1'b1;
   dpoam_drop_t drop;
   dpoam_poh_t poh = '0;
   dpoam_upstream_t upstream = '0;
   logic pte = 1'b0; // Pointer tracking pin
   logic slip_ov = 1'b0;
   logic slip_un = 1'b0;
   logic fifo_recenter;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [9:0] adr = 10'h000;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack;
   logic irq;
   logic [1:0] cover_sel = 2'h0; // Parity coverage of the source
   logic [7:0] rd; // Last read byte
   int num_errors = 0;
   int cmp_count = 0;
   always #50 clock = ~clock;
   dpoam_drop_source src (.clock(clock), .rst(rst), .cover_sel(cover_sel), .drop(drop));
   dpoam_monitor uut (.clock(clock), .rst(rst), .drop(drop), .poh(poh), .upstream(upstream),
      .pointer_track_enable(pte), .slip_overflow(slip_ov), .slip_underflow(slip_un),
      .fifo_recenter(fifo_recenter), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One classic cycle; request held until ack is seen at an edge
   task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clock);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; wdat <= {24'h0, d};
      do begin
         @(posedge clock);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rd = rdat[7:0];
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      if (n >= 20) chk(8'hee, 8'h00);
   endtask
   task automatic rdchk(input logic [7:0] idx, input logic [7:0] msk, input logic [7:0] exp);
      wb(1'b0, idx, 8'h00);
      chk(rd & msk, exp);
   endtask
   // Count POH strobes, one every two cycles: kind 2=G1, 1=C2, 0=J1
   task automatic strobe(input int kind, input logic [7:0] v, input int count);
      for (int i = 0; i < count; i++) begin
         @(posedge clock);
         poh <= '{g1: kind == 2, c2: kind == 1, j1: kind == 0, value: v};
         @(posedge clock);
         poh <= '0;
      end
   endtask
   function automatic logic [7:0] tbyte(input int sel, input int i);
      tbyte = (i == 0) ? 8'h80 : 8'((8'h20 + i + sel) & 8'h7f);
   endfunction
   task automatic send_msg(input int sel, input int count);
      for (int m = 0; m < count; m++) begin
         for (int i = 0; i < 16; i++) strobe(0, tbyte(sel, i), 1);
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs;
      rdchk(DPOAM_IDX_CTRL, 8'h3f, DPOAM_CTRL_RESET);
      rdchk(DPOAM_IDX_MASK, 8'hff, DPOAM_MASK_RESET);
      rdchk(DPOAM_IDX_C2EXP, 8'hff, DPOAM_C2EXP_RESET);
      wb(1'b1, DPOAM_IDX_STATUS, 8'hff);
      rdchk(DPOAM_IDX_STATUS, 8'hff, 8'h00);
      rdchk(8'h40, 8'hff, 8'h00);
   endtask
   // Each parity mode: correct coverage is quiet, the wrong one alarms and interrupts
   task automatic t_parity;
      logic [1:0] good [3] = '{2'h0, 2'h1, 2'h2};
      logic [1:0] bad [3] = '{2'h1, 2'h0, 2'h0};
      wb(1'b1, DPOAM_IDX_MASK, 8'h80);
      for (int m = 0; m < 3; m++) begin
         pte <= (m == 1);
         cover_sel <= good[m];
         wb(1'b1, DPOAM_IDX_CTRL, (m == 2) ? 8'h01 : 8'h00);
         wb(1'b1, DPOAM_IDX_EVENT, 8'hff);
         repeat (4) @(posedge clock);
         rdchk(DPOAM_IDX_EVENT, 8'h80, 8'h00);
         chk({7'h0, irq}, 8'h00);
         cover_sel <= bad[m];
         @(posedge clock);
         cover_sel <= good[m];
         repeat (3) @(posedge clock);
         rdchk(DPOAM_IDX_EVENT, 8'h80, 8'h80);
         chk({7'h0, irq}, 8'h01);
      end
      wb(1'b1, DPOAM_IDX_EVENT, 8'hff);
      repeat (3) @(posedge clock);
      chk({7'h0, irq}, 8'h00);
      wb(1'b1, DPOAM_IDX_MASK, 8'h00);
      wb(1'b1, DPOAM_IDX_CTRL, 8'h00);
      pte <= 1'b0;
      cover_sel <= 2'h0;
   endtask
   // Overflow then underflow, each recenters on the next cycle
   task automatic t_slip;
      for (int k = 0; k < 2; k++) begin
         wb(1'b1, DPOAM_IDX_EVENT, 8'hff);
         @(posedge clock);
         slip_ov <= (k == 0);
         slip_un <= (k == 1);
         @(posedge clock);
         slip_ov <= 1'b0;
         slip_un <= 1'b0;
         @(posedge clock);
         chk({7'h0, fifo_recenter}, 8'h01);
         @(posedge clock);
         chk({7'h0, fifo_recenter}, 8'h00);
         rdchk(DPOAM_IDX_EVENT, 8'h40, 8'h40);
      end
   endtask
   task automatic t_label;
      wb(1'b1, DPOAM_IDX_C2EXP, 8'h33); // Nonzero label so zero bytes also mismatch
      strobe(1, 8'h00, 4);
      rdchk(DPOAM_IDX_STATUS, 8'h18, 8'h00);
      strobe(1, 8'h00, 1);
      rdchk(DPOAM_IDX_STATUS, 8'h18, 8'h08);
      strobe(1, 8'h55, 4);
      rdchk(DPOAM_IDX_STATUS, 8'h18, 8'h08);
      strobe(1, 8'h55, 1);
      rdchk(DPOAM_IDX_STATUS, 8'h18, 8'h10);
      strobe(1, DPOAM_FIXED_LABEL, 4);
      rdchk(DPOAM_IDX_STATUS, 8'h18, 8'h10);
      strobe(1, DPOAM_FIXED_LABEL, 1);
      rdchk(DPOAM_IDX_STATUS, 8'h18, 8'h00);
      wb(1'b1, DPOAM_IDX_CTRL, 8'h04);
      strobe(1, DPOAM_FIXED_LABEL, 5);
      rdchk(DPOAM_IDX_STATUS, 8'h18, 8'h10);
      wb(1'b1, DPOAM_IDX_C2EXP, 8'h55);
      strobe(1, 8'h55, 5);
      rdchk(DPOAM_IDX_STATUS, 8'h18, 8'h00);
      wb(1'b1, DPOAM_IDX_CTRL, 8'h00);
   endtask
   // Five frames to detect, then ten frames to recover
   task automatic t_rdi;
      strobe(2, 8'h08, 4);
      rdchk(DPOAM_IDX_STATUS, 8'h20, 8'h00);
      strobe(2, 8'h08, 1);
      rdchk(DPOAM_IDX_STATUS, 8'h20, 8'h20);
      wb(1'b1, DPOAM_IDX_CTRL, 8'h02);
      strobe(2, 8'hf7, 9);
      rdchk(DPOAM_IDX_STATUS, 8'h20, 8'h20);
      strobe(2, 8'hf7, 1);
      rdchk(DPOAM_IDX_STATUS, 8'h20, 8'h00);
      wb(1'b1, DPOAM_IDX_CTRL, 8'h00);
   endtask
   task automatic t_trace;
      for (int i = 0; i < 16; i++) wb(1'b1, 8'(DPOAM_IDX_TRACE + i), tbyte(0, i));
      rdchk(DPOAM_IDX_STATUS, 8'h04, 8'h00);
      wb(1'b1, DPOAM_IDX_CTRL, 8'h18);
      rdchk(DPOAM_IDX_STATUS, 8'h04, 8'h04);
      send_msg(0, 3);
      rdchk(DPOAM_IDX_STATUS, 8'h06, 8'h00);
      send_msg(1, 3);
      rdchk(DPOAM_IDX_STATUS, 8'h06, 8'h02);
      send_msg(0, 2);
      rdchk(DPOAM_IDX_STATUS, 8'h06, 8'h02);
      wb(1'b1, DPOAM_IDX_EVENT, 8'hff);
      upstream.trace_pulse_loss <= 1'b1;
      repeat (3) @(posedge clock);
      upstream.trace_pulse_loss <= 1'b0;
      repeat (3) @(posedge clock);
      rdchk(DPOAM_IDX_EVENT, 8'h04, 8'h04);
      send_msg(0, 4);
      rdchk(DPOAM_IDX_STATUS, 8'h06, 8'h00);
   endtask
   // ----------------------------------------
   // Verdict, watchdog and main sequence
   // ----------------------------------------
   task automatic results;
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Whole run is under a thousand cycles; this limit of 60000 cycles is far beyond it
   initial begin
      #(100 * 60000);
      num_errors++;
      results();
   end
   initial begin
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      t_regs();
      t_parity();
      t_slip();
      t_label();
      t_rdi();
      t_trace();
      results();
   end
endmodule
